// ==== rtl/nfb_bus_op_decoder.v ====
// Host bus front end of a parallel NOR flash: bus decode and command modes.
`timescale 1ns/100ps
`include "nfb_regs.vh"
module nfb_bus_op_decoder #(
	parameter         AW         = 8,
	parameter         BLK_W      = 2,
	parameter [15:0]  MAKER_CODE = 16'h0055,  // Arbitrary value.
	parameter [15:0]  PART_CODE  = 16'h00AA   // Arbitrary value.
) (
	// System clock and reset.
	input  wire             i_sys_clk,
	input  wire             i_rst,
	// Host control pins.
	input  wire             i_link_clk,
	input  wire             i_rst_dev_n,
	input  wire             i_chip_sel_n,
	input  wire             i_out_en_n,
	input  wire             i_wr_en_n,
	input  wire             i_address_valid_n,
	// Host address and data pins.
	input  wire [AW-1:0]    i_addr,
	input  wire [15:0]      i_dq,
	output reg  [15:0]      o_dq,
	output reg              o_dq_oe,
	// Wait pin.
	output reg              o_wait,
	output reg              o_wait_oe,
	// Internal status.
	output reg  [BLK_W-1:0] o_block_sel,
	output reg  [1:0]       o_read_mode,
	output reg              o_ready
);

	// =========================================================================
	// Constants and states
	localparam       SW        = 6 + AW + 16;
	localparam       OW        = AW - BLK_W;
	localparam integer PROG_CYC_I = `NFB_PROG_CYC;
	localparam integer IDLE_CYC_I = `NFB_LINK_IDLE_CYC;
	localparam [7:0] PROG_CYC  = PROG_CYC_I[7:0];
	localparam [7:0] IDLE_CYC  = IDLE_CYC_I[7:0];
	localparam [2:0] CI_IDLE   = 3'h0;
	localparam [2:0] CI_PSETUP = 3'h1;
	localparam [2:0] CI_ESETUP = 3'h2;
	localparam [2:0] CI_CSETUP = 3'h3;
	localparam [2:0] CI_PBUSY  = 3'h4;
	localparam [2:0] CI_EBUSY  = 3'h5;

	// =========================================================================
	// Declarations
	wire [SW-1:0]    pin_s;
	wire             link_s;
	wire             rst_s;
	wire             ce_s;
	wire             oe_s;
	wire             we_s;
	wire             adv_s;
	wire [AW-1:0]    addr_s;
	wire [15:0]      dq_s;
	wire             dev_rst;
	wire             wr_act;
	wire             wr_done;
	wire             rd_sel;
	wire             link_edge;
	wire             sync_rd;
	wire             wait_asserted;
	wire             mem_we;
	wire [15:0]      mem_wdata;
	wire [15:0]      mem_rdata;
	reg              link_q;
	reg  [7:0]       idle_cnt;
	reg              wr_act_q;
	reg  [AW-1:0]    wr_addr;
	reg  [15:0]      wr_data;
	reg  [AW-1:0]    addr_lat;
	reg  [2:0]       ci_state;
	reg  [1:0]       mode;
	reg  [7:0]       status;
	reg  [15:0]      rcr;
	reg  [7:0]       op_cnt;
	reg  [AW-1:0]    op_addr;
	reg  [15:0]      op_data;
	reg  [2:0]       wait_cnt;
	reg  [15:0]      next_dq;

	// =========================================================================
	// Identifier space decode: maker, part, lock state and configuration.
	function [15:0] id_word;
		input [7:0]  offs;
		input [15:0] cfg;
		begin
			if (offs == `NFB_ID_MAKER) begin
				id_word = MAKER_CODE;
			end else if (offs == `NFB_ID_PART) begin
				id_word = PART_CODE;
			end else if (offs == `NFB_ID_LOCK) begin
				id_word = 16'h0000;                 // No block is locked.
			end else if (offs == `NFB_ID_RCR) begin
				id_word = cfg;
			end else begin
				id_word = 16'h0000;                 // Protection data reads zero.
			end
		end
	endfunction

	// =========================================================================
	// Pin synchronisers
	// Every pin passes two flops before any logic looks at it.
	nfb_sync #(
		.W(SW)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_d       ({i_link_clk, i_rst_dev_n, i_chip_sel_n, i_out_en_n,
		             i_wr_en_n, i_address_valid_n, i_addr, i_dq}),
		.o_q       (pin_s)
	);

	// Unpack the synchronised pins.
	assign link_s = pin_s[SW-1];
	assign rst_s  = pin_s[SW-2];
	assign ce_s   = pin_s[SW-3];
	assign oe_s   = pin_s[SW-4];
	assign we_s   = pin_s[SW-5];
	assign adv_s  = pin_s[SW-6];
	assign addr_s = pin_s[AW+15:16];
	assign dq_s   = pin_s[15:0];

	// =========================================================================
	// Bus operation decode
	// Device reset low overrides every other control input.
	assign dev_rst = i_rst | ~rst_s;
	// A write cycle needs select and write low with output enable high.
	assign wr_act  = rst_s & ~ce_s & ~we_s & oe_s;
	// The cycle ends on whichever of write or select rises first.
	assign wr_done = wr_act_q & ~wr_act & rst_s & oe_s;
	// A read needs select and output enable low, reset and write high.
	assign rd_sel  = rst_s & ~ce_s & ~oe_s & we_s;

	// Hold the last address and data seen during the write cycle.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			wr_act_q <= 1'b0;
			wr_addr  <= {AW{1'b0}};
			wr_data  <= 16'h0000;
		end else begin
			wr_act_q <= wr_act;
			if (wr_act) begin
				wr_addr <= addr_s;
				wr_data <= dq_s;
			end
		end
	end

	// Address latch is transparent while address valid is low.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			addr_lat <= {AW{1'b0}};
		end else if (~adv_s) begin
			addr_lat <= addr_s;
		end
	end

	// Upper address bits name the block of the access.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			o_block_sel <= {BLK_W{1'b0}};
		end else begin
			o_block_sel <= addr_lat[AW-1:OW];
		end
	end

	// =========================================================================
	// Command interpreter and internal algorithms
	// Codes are taken at any address; the address only matters as the
	// target of a program or erase. Reset aborts whatever is running, so a
	// partly written word or block simply keeps what it got so far.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			ci_state <= CI_IDLE;
			mode     <= `NFB_MODE_ARRAY;
			status   <= `NFB_SR_RESET;
			rcr      <= `NFB_RCR_RESET;
			op_cnt   <= 8'h00;
			op_addr  <= {AW{1'b0}};
			op_data  <= 16'h0000;
		end else begin
			// Running algorithms go on whatever the select pin does.
			case (ci_state)
				CI_PBUSY: begin
					if (op_cnt == 8'h00) begin
						ci_state                <= CI_IDLE;
						status[`NFB_SR_READY]   <= 1'b1;
					end else begin
						op_cnt <= op_cnt - 8'h01;
					end
				end
				CI_EBUSY: begin
					op_addr <= op_addr + {{(AW-1){1'b0}}, 1'b1};
					if (&op_addr[OW-1:0]) begin
						ci_state              <= CI_IDLE;
						status[`NFB_SR_READY] <= 1'b1;
					end
				end
				default: begin
				end
			endcase
			if (wr_done) begin
				case (ci_state)
					CI_IDLE: begin
						if (wr_data[7:0] == `NFB_CMD_READ_ARRAY) begin
							mode <= `NFB_MODE_ARRAY;
						end else if (wr_data[7:0] == `NFB_CMD_READ_STATUS) begin
							mode <= `NFB_MODE_STATUS;
						end else if (wr_data[7:0] == `NFB_CMD_READ_ID) begin
							mode <= `NFB_MODE_ID;
						end else if (wr_data[7:0] == `NFB_CMD_CLR_STATUS) begin
							status[`NFB_SR_ERASE_ERR] <= 1'b0;
							status[`NFB_SR_PROG_ERR]  <= 1'b0;
						end else if (wr_data[7:0] == `NFB_CMD_PROG_SETUP) begin
							ci_state <= CI_PSETUP;
							mode     <= `NFB_MODE_STATUS;
						end else if (wr_data[7:0] == `NFB_CMD_ERASE_SETUP) begin
							ci_state <= CI_ESETUP;
							mode     <= `NFB_MODE_STATUS;
						end else if (wr_data[7:0] == `NFB_CMD_CFG_SETUP) begin
							ci_state <= CI_CSETUP;
						end
						// Any other code keeps the mode as it is.
					end
					CI_PSETUP: begin
						ci_state              <= CI_PBUSY;
						op_addr               <= wr_addr;
						op_data               <= wr_data;
						op_cnt                <= PROG_CYC;
						status[`NFB_SR_READY] <= 1'b0;
					end
					CI_ESETUP: begin
						if (wr_data[7:0] == `NFB_CMD_CONFIRM) begin
							ci_state              <= CI_EBUSY;
							op_addr               <= {wr_addr[AW-1:OW], {OW{1'b0}}};
							status[`NFB_SR_READY] <= 1'b0;
						end else begin
							// A bad confirm flags both error bits.
							ci_state                  <= CI_IDLE;
							status[`NFB_SR_ERASE_ERR] <= 1'b1;
							status[`NFB_SR_PROG_ERR]  <= 1'b1;
						end
					end
					CI_CSETUP: begin
						ci_state <= CI_IDLE;
						if (wr_data[7:0] == `NFB_CMD_CFG_CONFIRM) begin
							rcr[15:8] <= wr_data[15:8];
						end
					end
					default: begin
						// While busy only the status read is heard.
						if (wr_data[7:0] == `NFB_CMD_READ_STATUS) begin
							mode <= `NFB_MODE_STATUS;
						end
					end
				endcase
			end
		end
	end

	// Program writes its one word at the end; erase walks the block.
	assign mem_we    = ((ci_state == CI_PBUSY) & (op_cnt == 8'h00)) |
	                   (ci_state == CI_EBUSY);
	assign mem_wdata = (ci_state == CI_EBUSY) ? `NFB_ERASED : op_data;

	// =========================================================================
	// Flash array
	nfb_mem #(
		.AW(AW),
		.DW(16)
	) u_mem (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_we      (mem_we & ~dev_rst),
		.i_waddr   (op_addr),
		.i_wdata   (mem_wdata),
		.i_raddr   (addr_lat),
		.o_rdata   (mem_rdata)
	);

	// =========================================================================
	// Link clock watch
	// The link clock counts as running while edges keep coming; a stopped
	// clock drops the block back to asynchronous reads.
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			link_q   <= 1'b0;
			idle_cnt <= IDLE_CYC;
		end else begin
			link_q <= link_s;
			if (link_edge) begin
				idle_cnt <= 8'h00;
			end else if (idle_cnt != IDLE_CYC) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

	assign link_edge = link_s & ~link_q;
	assign sync_rd   = (idle_cnt != IDLE_CYC) & ~rcr[`NFB_RCR_ASYNC] & ~wr_act;

	// =========================================================================
	// Wait generation
	// Each new address loads the latency, then link edges count it down.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			wait_cnt <= 3'h0;
		end else if (~adv_s) begin
			wait_cnt <= rcr[`NFB_RCR_LAT_MSB:`NFB_RCR_LAT_LSB];
		end else if (link_edge & (wait_cnt != 3'h0)) begin
			wait_cnt <= wait_cnt - 3'h1;
		end
	end

	// Data is invalid only in synchronous reads before latency expires.
	assign wait_asserted = sync_rd & (wait_cnt != 3'h0);

	// =========================================================================
	// Read data path
	// Choose the word for the current read mode.
	always @* begin
		case (mode)
			`NFB_MODE_STATUS: next_dq = {`NFB_ZERO_BYTE, status};
			`NFB_MODE_ID:     next_dq = id_word(addr_lat[7:0], rcr);
			default:          next_dq = mem_rdata;
		endcase
	end

	// Output drivers: data and wait float unless a read is under way.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			o_dq      <= 16'h0000;
			o_dq_oe   <= 1'b0;
			o_wait    <= 1'b0;
			o_wait_oe <= 1'b0;
		end else begin
			o_dq      <= next_dq;
			o_dq_oe   <= rd_sel;
			o_wait    <= wait_asserted ~^ rcr[`NFB_RCR_WAIT_POL];
			o_wait_oe <= rd_sel;
		end
	end

	// Mode and ready flags for observation.
	always @(posedge i_sys_clk) begin
		if (dev_rst) begin
			o_read_mode <= `NFB_MODE_ARRAY;
			o_ready     <= 1'b1;
		end else begin
			o_read_mode <= mode;
			o_ready     <= status[`NFB_SR_READY];
		end
	end

endmodule // nfb_bus_op_decoder

// ==== rtl/nfb_regs.vh ====
// Constants for the NOR flash bus operation decoder.
// =============================================================================
`ifndef NFB_REGS_VH
`define NFB_REGS_VH

// =============================================================================
// Command codes
`define NFB_CMD_READ_ARRAY  8'hFF
`define NFB_CMD_READ_STATUS 8'h70
`define NFB_CMD_READ_ID     8'h90
`define NFB_CMD_CLR_STATUS  8'h50
`define NFB_CMD_PROG_SETUP  8'h40
`define NFB_CMD_ERASE_SETUP 8'h20
`define NFB_CMD_CONFIRM     8'hD0
`define NFB_CMD_CFG_SETUP   8'h60
`define NFB_CMD_CFG_CONFIRM 8'h03

// =============================================================================
// Status byte and read configuration fields
`define NFB_SR_RESET        8'h80
`define NFB_SR_READY        7
`define NFB_SR_ERASE_ERR    5
`define NFB_SR_PROG_ERR     4
`define NFB_RCR_RESET       16'hBFCF
`define NFB_RCR_ASYNC       15
`define NFB_RCR_LAT_MSB     13
`define NFB_RCR_LAT_LSB     11
`define NFB_RCR_WAIT_POL    10

// =============================================================================
// Identifier offsets, read modes and data values
`define NFB_ID_MAKER        8'h00
`define NFB_ID_PART         8'h01
`define NFB_ID_LOCK         8'h02
`define NFB_ID_RCR          8'h05
`define NFB_MODE_ARRAY      2'h0
`define NFB_MODE_STATUS     2'h1
`define NFB_MODE_ID         2'h2
`define NFB_ERASED          16'hFFFF
`define NFB_ZERO_BYTE       8'h00

// =============================================================================
// Timing
`define NFB_CLK_NS          25
`define NFB_T_PROG_NS       500
`define NFB_PROG_CYC        ((`NFB_T_PROG_NS + `NFB_CLK_NS - 1) / `NFB_CLK_NS)
`define NFB_T_LINK_IDLE_NS  400
`define NFB_LINK_IDLE_CYC   (`NFB_T_LINK_IDLE_NS / `NFB_CLK_NS)

`endif

// ==== rtl/nfb_sync.v ====
// Two-flop synchroniser for the asynchronous pin inputs.
`timescale 1ns/100ps
module nfb_sync #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         i_sys_clk,
	input  wire         i_rst,
	// Raw pins and their synchronised copy.
	input  wire [W-1:0] i_d,
	output reg  [W-1:0] o_q
);
	reg [W-1:0] meta;

	// The first stage feeds the second stage and nothing else.
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			meta <= {W{1'b0}};
			o_q  <= {W{1'b0}};
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule // nfb_sync

// ==== rtl/nfb_mem.v ====
// Word array of the flash with a registered read port.
`timescale 1ns/100ps
module nfb_mem #(
	parameter AW = 8,
	parameter DW = 16
) (
	// Clock and reset.
	input  wire          i_sys_clk,
	input  wire          i_rst,
	// Write port used by the internal algorithms.
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [DW-1:0] i_wdata,
	// Read port.
	input  wire [AW-1:0] i_raddr,
	output reg  [DW-1:0] o_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write when enabled and read each cycle; the read word lands in a register.
	always @(posedge i_sys_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_rst) begin
			o_rdata <= {DW{1'b0}};
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule // nfb_mem

// ==== bench/nfb_host_model.sv ====
// Host bus master model that drives the flash pins.
`timescale 1ns/100ps
module nfb_host_model #(
	parameter AW = 8
) (
	// Clock and command from the bench.
	input  wire          i_sys_clk,
	input  wire          i_go,
	input  wire [1:0]    i_kind,
	input  wire [AW-1:0] i_addr,
	input  wire [15:0]   i_data,
	// Answer to the bench.
	output reg           o_done,
	output reg  [15:0]   o_rdata,
	output reg  [2:0]    o_seen,
	// Pins driven by the device.
	input  wire [15:0]   i_dq,
	input  wire          i_dq_oe,
	input  wire          i_wait,
	input  wire          i_wait_oe,
	// Pins driven towards the device.
	output reg           o_chip_sel_n,
	output reg           o_out_en_n,
	output reg           o_wr_en_n,
	output reg           o_address_valid_n,
	output reg           o_link_clk,
	output reg  [AW-1:0] o_addr,
	output reg  [15:0]   o_dq
);
	// Kinds are 0 write, 1 async read, 2 burst read, 3 output enable alone.
	initial begin
		{o_done, o_rdata, o_seen, o_link_clk} = 21'h000000;
		{o_chip_sel_n, o_out_en_n, o_wr_en_n, o_address_valid_n} = 4'hF;
		o_addr = {AW{1'b0}};
		o_dq = 16'h0000;
		forever begin
			@(posedge i_sys_clk);
			o_done <= 1'b0;
			if (i_go) begin
				o_addr <= i_addr;
				o_dq <= i_data;
				o_address_valid_n <= (i_kind == 2'h3);
				o_chip_sel_n <= (i_kind == 2'h3);
				o_wr_en_n <= (i_kind != 2'h0);  // Writes keep output enable high.
				o_out_en_n <= (i_kind == 2'h0);  // Reads need select and enable low.
				if (i_kind == 2'h2) begin
					// Latch the address, then run the link clock only within the frame.
					repeat (3) @(posedge i_sys_clk);
					o_address_valid_n <= 1'b1;
					#37;
					repeat (14) #100 o_link_clk = ~o_link_clk;
					repeat (30) @(posedge i_sys_clk);
				end else begin
					repeat ((i_kind == 2'h0) ? 3 : 9) @(posedge i_sys_clk);
				end
				o_rdata <= i_dq;
				o_seen <= {i_dq_oe, i_wait_oe, i_wait};
				// Controls return high; address and data lines show the inverse of their last value.
				{o_chip_sel_n, o_out_en_n, o_wr_en_n, o_address_valid_n} <= 4'hF;
				o_dq <= ~o_dq;
				o_addr <= ~o_addr;
				repeat (6) @(posedge i_sys_clk);
				o_done <= 1'b1;
			end
		end
	end
endmodule // nfb_host_model

// ==== bench/nfb_bus_op_decoder_sva.sv ====
// Concurrent checks on the pins of the flash bus front end.
`timescale 1ns/100ps
module nfb_bus_op_decoder_sva #(
	parameter AW    = 8,
	parameter BLK_W = 2
) (
	// Clock and reset.
	input wire             i_sys_clk,
	input wire             i_rst,
	// Host pins.
	input wire             i_rst_dev_n,
	input wire             i_chip_sel_n,
	input wire             i_out_en_n,
	input wire             i_wr_en_n,
	input wire             i_address_valid_n,
	input wire [AW-1:0]    i_addr,
	// Device outputs.
	input wire [15:0]      o_dq,
	input wire             o_dq_oe,
	input wire             o_wait_oe,
	input wire [BLK_W-1:0] o_block_sel,
	input wire [1:0]       o_read_mode,
	input wire             o_ready
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// ========
	// Output drivers and reset state.
	property p_oe_float;
		i_out_en_n [*4] |-> !o_dq_oe && !o_wait_oe;
	endproperty
	a_oe_float: assert property (p_oe_float)
		else $error("Outputs driven with output enable high.");
	property p_sel_float;
		i_chip_sel_n [*4] |-> !o_dq_oe && !o_wait_oe;
	endproperty
	a_sel_float: assert property (p_sel_float)
		else $error("Outputs driven while deselected.");
	property p_rst_state;
		!i_rst_dev_n [*4] |-> !o_dq_oe && o_ready && o_read_mode == 2'h0;
	endproperty
	a_rst_state: assert property (p_rst_state)
		else $error("Device reset did not float and restore state.");
	property p_read_drive;
		(!i_chip_sel_n && !i_out_en_n && i_wr_en_n && i_rst_dev_n) [*5] |-> o_dq_oe && o_wait_oe;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("Read cycle without driven outputs.");
	property p_oe_cause;
		$rose(o_dq_oe) |-> !$past(i_out_en_n, 2) && !$past(i_chip_sel_n, 2) && i_rst_dev_n;
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("Outputs enabled without a read cycle.");
	// ========
	// Modes, algorithm and address.
	property p_prog_status;
		$fell(o_ready) |-> ##[0:3] o_read_mode == 2'h1;
	endproperty
	a_prog_status: assert property (p_prog_status)
		else $error("Busy without status mode.");
	property p_prog_hold;
		$fell(o_ready) ##1 i_rst_dev_n [*8] |-> !o_ready;
	endproperty
	a_prog_hold: assert property (p_prog_hold)
		else $error("Algorithm ended too early.");
	property p_block;
		(!i_address_valid_n && !i_chip_sel_n && i_rst_dev_n && $stable(i_addr)) [*5]
			|-> o_block_sel == i_addr[AW-1:AW-BLK_W];
	endproperty
	a_block: assert property (p_block)
		else $error("Block select does not follow the address.");
	property p_status_hi;
		(o_dq_oe && o_read_mode == 2'h1) [*6] |-> o_dq[15:8] == 8'h00;
	endproperty
	a_status_hi: assert property (p_status_hi)
		else $error("Status read with nonzero high byte.");
	// Main scenarios reached.
	c_prog: cover property ($fell(o_ready));
	c_id: cover property (o_dq_oe && o_read_mode == 2'h2);
	c_abort: cover property (!i_rst_dev_n && !o_ready);
endmodule // nfb_bus_op_decoder_sva

bind nfb_bus_op_decoder nfb_bus_op_decoder_sva #(.AW(AW), .BLK_W(BLK_W)) u_sva (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rst_dev_n(i_rst_dev_n),
	.i_chip_sel_n(i_chip_sel_n), .i_out_en_n(i_out_en_n), .i_wr_en_n(i_wr_en_n),
	.i_address_valid_n(i_address_valid_n), .i_addr(i_addr), .o_dq(o_dq),
	.o_dq_oe(o_dq_oe), .o_wait_oe(o_wait_oe), .o_block_sel(o_block_sel),
	.o_read_mode(o_read_mode), .o_ready(o_ready)
);

// ==== bench/tb_nor_flash_bus_op_decoder.sv ====
// Self-checking bench for the flash bus front end driven by a host model.
`timescale 1ns/100ps
`include "nfb_regs.vh"
module tb_nor_flash_bus_op_decoder;
	// ========
	// Signals
	localparam [15:0] MAKER = 16'h0033;  // Arbitrary value.
	localparam [15:0] PART  = 16'h00CC;  // Arbitrary value.
	reg         clk, rst, rst_dev_n, go;
	reg  [1:0]  kind;
	reg  [7:0]  addr, cfg, offs;
	reg  [15:0] data, wd;
	reg  [31:0] r;
	reg  [15:0] mem [0:255];
	reg  [7:0]  adr [0:3];
	integer     mismatches, total_checks, seed, i;
	wire        done, cs_n, oe_n, we_n, av_n, link, dq_oe, wt, wt_oe, ready;
	wire [2:0]  seen;
	wire [1:0]  blk, mode;
	wire [7:0]  h_addr;
	wire [15:0] rdata, h_dq, dev_dq, dq_bus;
	// The shared data bus carries whichever side is driving.
	assign dq_bus = dq_oe ? dev_dq : h_dq;
	always #12.5 clk = ~clk;
	nfb_bus_op_decoder #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uut (
		.i_sys_clk(clk), .i_rst(rst), .i_link_clk(link), .i_rst_dev_n(rst_dev_n),
		.i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_wr_en_n(we_n),
		.i_address_valid_n(av_n), .i_addr(h_addr), .i_dq(dq_bus), .o_dq(dev_dq),
		.o_dq_oe(dq_oe), .o_wait(wt), .o_wait_oe(wt_oe), .o_block_sel(blk),
		.o_read_mode(mode), .o_ready(ready));
	nfb_host_model u_host (
		.i_sys_clk(clk), .i_go(go), .i_kind(kind), .i_addr(addr), .i_data(data),
		.o_done(done), .o_rdata(rdata), .o_seen(seen), .i_dq(dq_bus), .i_dq_oe(dq_oe),
		.i_wait(wt), .i_wait_oe(wt_oe), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n),
		.o_wr_en_n(we_n), .o_address_valid_n(av_n), .o_link_clk(link),
		.o_addr(h_addr), .o_dq(h_dq));
	// ========
	// Helpers
	function [15:0] exp_id(input [7:0] off);
		exp_id = (off == 8'h00) ? MAKER : (off == 8'h01) ? PART :
			(off == 8'h05) ? `NFB_RCR_RESET : 16'h0000;
	endfunction
	task check(input [15:0] seen_v, input [15:0] exp_v);
		begin
			total_checks = total_checks + 1;
			if (seen_v !== exp_v) begin
				mismatches = mismatches + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
			end
		end
	endtask
	task wait_done;
		integer n;
		begin
			n = 0;
			while (done !== 1'b1 && n < 300) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n >= 300) check(16'h0000, 16'h0001);
		end
	endtask
	task op(input [1:0] k, input [7:0] a, input [15:0] d);
		begin
			go <= 1'b1;
			kind <= k;
			addr <= a;
			data <= d;
			@(posedge clk);
			go <= 1'b0;
			wait_done;
		end
	endtask
	task print_verdict;
		begin
			if (mismatches == 0 && total_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Watchdog sized well above the expected run.
	initial begin
		repeat (6000) @(posedge clk);
		mismatches = mismatches + 1;
		print_verdict;
	end
	// ========
	// Main sequence
	initial begin
		{clk, rst, rst_dev_n, go, kind, addr, data} = 30'h10000000;
		mismatches = 0;
		total_checks = 0;
		seed = 32'h0012;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rst_dev_n <= 1'b1;  // Device reset follows the system reset.
		repeat (6) @(posedge clk);  // Wake-up gap before any access.
		check(mode, `NFB_MODE_ARRAY);
		check(ready, 1'b1);
		op(2'h1, 8'h10, 16'h0000);
		check(seen, 3'b110);
		op(2'h3, 8'h10, 16'h0000);
		check(seen[2:1], 2'b00);
		// Program corner and random words; each runs on after deselect.
		for (i = 0; i < 4; i = i + 1) begin
			r = $random(seed);
			adr[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
			wd = (i == 0) ? 16'h0000 : r[23:8];
			op(2'h0, adr[i], {8'h00, `NFB_CMD_PROG_SETUP});
			op(2'h0, adr[i], wd);
			check(mode, `NFB_MODE_STATUS);
			mem[adr[i]] = wd;
			repeat (25) @(posedge clk);
			check(ready, 1'b1);
		end
		r = $random(seed);
		op(2'h0, r[7:0], {8'h00, `NFB_CMD_READ_ARRAY});
		check(mode, `NFB_MODE_ARRAY);
		for (i = 0; i < 4; i = i + 1) begin
			op(2'h1, adr[i], 16'h0000);
			check(rdata, mem[adr[i]]);
			check(blk, adr[i][7:6]);
		end
		op(2'h0, r[15:8], {8'h00, `NFB_CMD_READ_STATUS});
		op(2'h1, r[15:8], 16'h0000);
		check(rdata, {8'h00, `NFB_SR_RESET});
		op(2'h0, r[23:16], {8'h00, `NFB_CMD_READ_ID});
		check(mode, `NFB_MODE_ID);
		for (i = 0; i < 4; i = i + 1) begin
			offs = (i == 3) ? 8'h05 : i[7:0];
			op(2'h1, offs, 16'h0000);
			check(rdata, exp_id(offs));
		end
		op(2'h0, r[31:24], 16'h0012);
		check(mode, `NFB_MODE_ID);
		// Erase the top block, then a bad confirm that flags both error bits.
		op(2'h0, 8'hC0, {8'h00, `NFB_CMD_ERASE_SETUP});
		op(2'h0, 8'hC5, {8'h00, `NFB_CMD_CONFIRM});
		check(ready, 1'b0);
		repeat (70) @(posedge clk);
		check({ready, mode}, {1'b1, `NFB_MODE_STATUS});
		op(2'h0, 8'h00, {8'h00, `NFB_CMD_READ_ARRAY});
		op(2'h1, 8'hFF, 16'h0000);
		check(rdata, `NFB_ERASED);
		op(2'h0, 8'h00, {8'h00, `NFB_CMD_ERASE_SETUP});
		op(2'h0, 8'h00, 16'h0012);
		op(2'h1, 8'h00, 16'h0000);
		wd = (16'h0001 << `NFB_SR_ERASE_ERR) | (16'h0001 << `NFB_SR_PROG_ERR);
		check(rdata, {8'h00, `NFB_SR_RESET} | wd);
		op(2'h0, 8'h00, {8'h00, `NFB_CMD_CLR_STATUS});
		op(2'h1, 8'h00, 16'h0000);
		check(rdata, {8'h00, `NFB_SR_RESET});
		// Device reset in the middle of a program.
		op(2'h0, 8'h20, {8'h00, `NFB_CMD_PROG_SETUP});
		op(2'h0, 8'h20, 16'h1234);
		check(ready, 1'b0);
		rst_dev_n <= 1'b0;
		op(2'h1, 8'h20, 16'h0000);
		check(seen[2:1], 2'b00);
		check({ready, mode}, {1'b1, `NFB_MODE_ARRAY});
		rst_dev_n <= 1'b1;
		repeat (6) @(posedge clk);
		// Burst reads with wait of either polarity.
		for (i = 0; i < 2; i = i + 1) begin
			cfg = (i == 0) ? 8'h3C : 8'h38;
			op(2'h0, 8'h00, {8'h00, `NFB_CMD_CFG_SETUP});
			op(2'h0, 8'h00, {cfg, `NFB_CMD_CFG_CONFIRM});
			go <= 1'b1;
			kind <= 2'h2;
			addr <= 8'h40;
			@(posedge clk);
			go <= 1'b0;
			repeat (20) @(posedge clk);
			check({wt_oe, wt}, {1'b1, cfg[2]});
			repeat (55) @(posedge clk);
			check({wt_oe, wt}, {1'b1, ~cfg[2]});
			wait_done;
		end
		print_verdict;
	end
endmodule // tb_nor_flash_bus_op_decoder
